// >>> core/weld_start_ctrl.sv
// Weld start, error policy, error-conditioned sequencer and configuration
// decode of a resistance weld sequence controller.
// Assumes all machine inputs synchronous to sys_clk; program memory answers
// prog_addr combinationally in the same cycle.
// Notes on behaviour
// - Jump when indexed error 1..96 is set
// - Any selector jumps when some error set
// - Jump when indexed error 1..96 is clear
// - All selector jumps only if none set
// - Stop: valve releases normally, further welds blocked
// - Continue: errors set no lockout; a lockout left from stop or hold still blocks until reset
// - Hold: valve kept on, welds blocked
// - Internal select uses stored schedule number
// - External select reads seven binary code inputs
// - External codes above 99 become 99
// - Palm inputs must close within half second
// - Palm mode keeps primary and second initiations
// - Current feedback from selectable coil source
// - Four pressure modes enable sense, regulate
// - PSI mode maps 4..20 mA to 0..100
// - Force unit change invalidates stored pressure data
// - Sequencer runs only while enabled
module weld_start_ctrl #(
  parameter int PALM_WINDOW_CYC = weld_pkg::PALM_WINDOW_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration settings
  input wire weld_pkg::config_t cfg,
  // Initiation switches
  input wire logic primary_initiation,
  input wire logic second_initiation,
  input wire logic palm_input_a,
  input wire logic palm_input_b,
  input wire logic [6:0] sched_code_input,
  // Error sources and weld handshake
  input wire logic [weld_pkg::ERR_COUNT-1:0] err_active,
  input wire logic err_routed,
  input wire logic err_reset,
  input wire logic weld_done,
  // Weld outputs
  output logic weld_valve,
  output logic weld_start,
  output logic [6:0] weld_sched,
  output logic weld_lockout,
  output logic error_output,
  // Sequencer program port
  output logic [7:0] prog_addr,
  input wire weld_pkg::prog_line_t prog_line,
  output logic seq_busy,
  output logic seq_done,
  // Current feedback
  input wire weld_pkg::coil_t coil,
  output logic [15:0] current_fb,
  // Pressure system
  input wire logic [7:0] press_ma_x10,
  input wire logic force_data_ack,
  output logic [6:0] press_psi,
  output logic pressure_sense_en,
  output logic pressure_regulate_en,
  output logic force_data_invalid
);

  weld_pkg::ctrl_state_t r;
  weld_pkg::ctrl_state_t n;
  logic [6:0] sel_sched;
  logic palm_fire;
  logic prim_rise;
  logic sec_rise;
  logic start_any;
  logic [6:0] start_sched;
  logic err_latch;
  logic seq_jump;
  logic [7:0] ma_clamped;
  logic [9:0] psi_scaled;

  // Error test shared by both branch kinds; index 0 stands for the set
  function automatic logic err_hit(
    input logic [weld_pkg::ERR_COUNT-1:0] errs,
    input logic [6:0] sel,
    input logic want_on
  );
    logic hit;
    hit = 1'b0;
    if (sel == weld_pkg::ERR_SEL_WHOLE) begin
      hit = want_on ? (|errs) : ~(|errs);
    end else if (sel <= 7'(weld_pkg::ERR_COUNT)) begin
      hit = want_on ? errs[sel - 7'h01] : ~errs[sel - 7'h01];
    end
    return hit;
  endfunction : err_hit

  sched_select u_sched_select (
    .sched_src(cfg.sched_src),
    .use_schedule(cfg.use_schedule),
    .sched_code(sched_code_input),
    .sched(sel_sched)
  );

  palm_window #(
    .WINDOW_CYC(PALM_WINDOW_CYC)
  ) u_palm_window (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(cfg.dual_hand_initiation),
    .palm_input_a(palm_input_a),
    .palm_input_b(palm_input_b),
    .fire(palm_fire)
  );

  // Initiation edges; primary and palm share the selected schedule
  assign prim_rise = primary_initiation & ~r.prim_q;
  assign sec_rise = second_initiation & ~r.sec_q;
  assign start_any = prim_rise | palm_fire | sec_rise;
  assign start_sched = (prim_rise | palm_fire) ? sel_sched :
                       weld_pkg::SCHED_SECOND;
  assign err_latch = err_routed & (cfg.policy != weld_pkg::pol_continue);

  // Transducer clamp to the 4..20 mA span before scaling
  assign ma_clamped = (press_ma_x10 < weld_pkg::MA_X10_ZERO) ?
                      weld_pkg::MA_X10_ZERO :
                      (press_ma_x10 > weld_pkg::MA_X10_FULL) ?
                      weld_pkg::MA_X10_FULL : press_ma_x10;
  assign psi_scaled = {2'b00, ma_clamped - weld_pkg::MA_X10_ZERO} *
                      weld_pkg::PSI_MUL;

  // Output mapping
  assign weld_valve = r.valve;
  assign weld_start = r.start;
  assign weld_sched = r.sched;
  assign weld_lockout = r.lock;
  assign error_output = r.err_out;
  assign prog_addr = r.pc;
  assign seq_busy = (r.seq == weld_pkg::sq_run);
  assign seq_done = (r.seq == weld_pkg::sq_done);
  assign current_fb = r.fb;
  assign press_psi = r.psi;
  assign pressure_sense_en = r.sense_en;
  assign pressure_regulate_en = r.reg_en;
  assign force_data_invalid = r.invalid;

  // Next-state logic for weld, sequencer and configuration decode
  always_comb begin
    n = r;
    seq_jump = 1'b0;
    n.start = 1'b0;
    n.prim_q = primary_initiation;
    n.sec_q = second_initiation;
    n.err_out = err_routed;
    // A new error wins over a reset that arrives in the same cycle
    n.lock = err_latch | (r.lock & ~err_reset);

    // Weld cycle
    case (r.weld)
      weld_pkg::wd_idle: begin
        if (start_any && !r.lock) begin
          n.weld = weld_pkg::wd_weld;
          n.valve = 1'b1;
          n.start = 1'b1;
          n.sched = start_sched;
        end
      end
      weld_pkg::wd_weld: begin
        if (weld_done) begin
          if (cfg.policy == weld_pkg::pol_hold && (r.lock || err_routed)) begin
            n.weld = weld_pkg::wd_hold;
          end else begin
            n.weld = weld_pkg::wd_idle;
            n.valve = 1'b0;
          end
        end
      end
      weld_pkg::wd_hold: begin
        if (err_reset) begin
          n.weld = weld_pkg::wd_idle;
          n.valve = 1'b0;
        end
      end
      default: begin
        n.weld = weld_pkg::wd_idle;
        n.valve = 1'b0;
      end
    endcase

    // Sequencer: one program line per cycle
    case (r.seq)
      weld_pkg::sq_idle: begin
        if (cfg.seq_enable) begin
          n.seq = weld_pkg::sq_run;
          n.pc = weld_pkg::LINE_FIRST;
        end
      end
      weld_pkg::sq_run: begin
        case (prog_line.op)
          weld_pkg::op_err_on_jump: begin
            seq_jump = err_hit(err_active, prog_line.err_sel, 1'b1);
          end
          weld_pkg::op_err_off_jump: begin
            seq_jump = err_hit(err_active, prog_line.err_sel, 1'b0);
          end
          default: begin
            seq_jump = 1'b0;
          end
        endcase
        if (prog_line.op == weld_pkg::op_end) begin
          n.seq = weld_pkg::sq_done;
        end else if (seq_jump) begin
          n.pc = prog_line.target;
        end else if (r.pc == weld_pkg::LINE_LAST) begin
          n.seq = weld_pkg::sq_done;
        end else begin
          n.pc = r.pc + 8'h01;
        end
      end
      weld_pkg::sq_done: begin
        n.seq = weld_pkg::sq_done;
      end
      default: begin
        n.seq = weld_pkg::sq_idle;
      end
    endcase
    // Disable overrides everything so a half-run program restarts cleanly
    if (!cfg.seq_enable) begin
      n.seq = weld_pkg::sq_idle;
      n.pc = weld_pkg::LINE_FIRST;
    end

    // Current feedback source
    case (cfg.fb_src)
      weld_pkg::fb_secondary: n.fb = coil.secondary;
      weld_pkg::fb_sec_with_pri: n.fb = coil.sec_with_pri;
      default: n.fb = coil.primary;
    endcase

    // Pressure system functions
    n.sense_en = (cfg.press_mode == weld_pkg::pressure_sense_only) ||
      (cfg.press_mode == weld_pkg::pressure_sense_and_regulate);
    n.reg_en = (cfg.press_mode == weld_pkg::pressure_regulate_only) ||
      (cfg.press_mode == weld_pkg::pressure_sense_and_regulate);
    if (cfg.force_unit == weld_pkg::unit_psi &&
        cfg.press_mode != weld_pkg::pressure_off) begin
      n.psi = 7'(psi_scaled >> weld_pkg::PSI_SHIFT);
    end else begin
      n.psi = 7'h00;
    end

    // Unit change flags stored data; first sample after reset is no change
    n.unit_q = cfg.force_unit;
    n.unit_seen = 1'b1;
    n.invalid = (r.unit_seen && cfg.force_unit != r.unit_q) |
                (r.invalid & ~force_data_ack);
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= weld_pkg::CTRL_RESET;
    end else begin
      r <= n;
    end
  end

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_ERR_ON_IDX: assert property (seq_busy &&
    prog_line.op == weld_pkg::op_err_on_jump &&
    prog_line.err_sel != 7'h00 && prog_line.err_sel <= 7'h60 &&
    err_active[prog_line.err_sel - 7'h01] && cfg.seq_enable
    |=> prog_addr == $past(prog_line.target))
    else $error("indexed error-on jump not taken");
  AST_ERR_ANY: assert property (seq_busy &&
    prog_line.op == weld_pkg::op_err_on_jump &&
    prog_line.err_sel == 7'h00 && !(|err_active) &&
    r.pc != weld_pkg::LINE_LAST && cfg.seq_enable
    |=> prog_addr == $past(prog_addr) + 8'h01)
    else $error("any-error jump taken with no error");
  AST_ERR_ALL: assert property (seq_busy &&
    prog_line.op == weld_pkg::op_err_off_jump &&
    prog_line.err_sel == 7'h00 && (|err_active) &&
    r.pc != weld_pkg::LINE_LAST && cfg.seq_enable
    |=> prog_addr == $past(prog_addr) + 8'h01)
    else $error("all-clear jump taken with an error set");
  AST_LOCK_BLOCKS: assert property (weld_lockout && start_any
    |=> !weld_start)
    else $error("weld started under lockout");
  AST_CONT_NO_LOCK: assert property ($rose(weld_lockout)
    |-> $past(cfg.policy) != weld_pkg::pol_continue)
    else $error("lockout under continue policy");
  AST_HOLD_VALVE: assert property (r.weld == weld_pkg::wd_hold && !err_reset
    |=> weld_valve [*2] or (weld_valve ##1 !weld_valve))
    else $error("valve dropped during hold");
  AST_CLAMP: assert property (cfg.sched_src == weld_pkg::src_external &&
    sched_code_input > 7'h63 |-> sel_sched == 7'h63)
    else $error("external code not clamped");
  AST_SECOND_SCHED: assert property (r.weld == weld_pkg::wd_idle &&
    !weld_lockout && sec_rise && !prim_rise && !palm_fire
    |=> weld_start && weld_sched == 7'h14)
    else $error("second initiation not on schedule 20");
  AST_FB_SRC: assert property (cfg.fb_src == weld_pkg::fb_secondary
    |=> current_fb == $past(coil.secondary))
    else $error("feedback source wrong");
  AST_PSI_FULL: assert property (cfg.force_unit == weld_pkg::unit_psi &&
    cfg.press_mode != weld_pkg::pressure_off && press_ma_x10 >= 8'hC8
    |=> press_psi == 7'h64)
    else $error("20 mA not 100 PSI");
  AST_UNIT_INVALID: assert property (r.unit_seen && $changed(cfg.force_unit)
    |=> force_data_invalid)
    else $error("unit change not flagged");
  AST_SEQ_OFF: assert property (!cfg.seq_enable
    |=> !seq_busy && !seq_done && prog_addr == 8'h01)
    else $error("sequencer active while disabled");
  AST_END_STOPS: assert property (seq_busy && cfg.seq_enable &&
    prog_line.op == weld_pkg::op_end
    |=> seq_done && $stable(prog_addr))
    else $error("end did not stop sequencer");
  AST_RESET_CLEARS: assert property (weld_lockout && err_reset && !err_routed
    |=> !weld_lockout)
    else $error("error reset did not clear lockout");

  CVR_WELD: cover property (weld_start);
  CVR_HOLD: cover property (r.weld == weld_pkg::wd_hold ##1 err_reset);
  CVR_JUMP: cover property (seq_busy && seq_jump);
  CVR_PALM: cover property (palm_fire);

endmodule : weld_start_ctrl

// >>> core/weld_pkg.sv
// Shared constants, enumerations and carrier structs of the weld start and
// error policy controller.
// Assumes one 40 MHz system clock and an asynchronous active-low reset.
package weld_pkg;

  // Timing: palm coincidence window, derived to cycles (rounded down)
  localparam int CLK_PERIOD_NS = 25;
  localparam int PALM_WINDOW_MS = 500;
  localparam int PALM_WINDOW_CYC = PALM_WINDOW_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PALM_CNT_W = 25;

  // Error set and program limits
  localparam int ERR_COUNT = 96;
  localparam logic [6:0] ERR_SEL_WHOLE = 7'h00;
  localparam logic [7:0] LINE_FIRST = 8'h01;
  localparam logic [7:0] LINE_LAST = 8'hC8;

  // Schedule numbers
  localparam logic [6:0] SCHED_MAX = 7'h63;
  localparam logic [6:0] SCHED_SECOND = 7'h14;

  // Transducer scale, input in tenths of a milliamp
  localparam logic [7:0] MA_X10_ZERO = 8'h28;
  localparam logic [7:0] MA_X10_FULL = 8'hC8;
  localparam logic [9:0] PSI_MUL = 10'h005;
  localparam int PSI_SHIFT = 3;

  typedef enum logic [1:0] {
    pol_stop = 2'h0, pol_continue = 2'h1, pol_hold = 2'h2
  } policy_t;
  typedef enum logic {src_internal = 1'b0, src_external = 1'b1} sched_src_t;
  typedef enum logic [1:0] {
    fb_primary = 2'h0, fb_secondary = 2'h1, fb_sec_with_pri = 2'h2
  } fb_src_t;
  typedef enum logic [1:0] {
    pressure_off = 2'h0, pressure_sense_only = 2'h1,
    pressure_regulate_only = 2'h2, pressure_sense_and_regulate = 2'h3
  } press_mode_t;
  typedef enum logic [1:0] {
    unit_ma = 2'h0, calibrated_force_unit = 2'h1, unit_psi = 2'h2,
    unit_lb = 2'h3
  } force_unit_t;
  typedef enum logic [2:0] {
    op_blank = 3'h0, op_step = 3'h1, op_end = 3'h2,
    op_err_on_jump = 3'h3, op_err_off_jump = 3'h4
  } opcode_t;
  typedef enum logic [2:0] {
    sq_idle = 3'b001, sq_run = 3'b010, sq_done = 3'b100
  } seq_state_t;
  typedef enum logic [2:0] {
    wd_idle = 3'b001, wd_weld = 3'b010, wd_hold = 3'b100
  } weld_state_t;

  typedef struct packed {
    opcode_t op;
    logic [6:0] err_sel;
    logic [7:0] target;
  } prog_line_t;

  typedef struct packed {
    policy_t policy;
    sched_src_t sched_src;
    logic dual_hand_initiation;
    fb_src_t fb_src;
    press_mode_t press_mode;
    force_unit_t force_unit;
    logic seq_enable;
    logic [6:0] use_schedule;
  } config_t;

  typedef struct packed {
    logic [15:0] primary;
    logic [15:0] secondary;
    logic [15:0] sec_with_pri;
  } coil_t;

  typedef struct packed {
    logic a_q;
    logic b_q;
    logic armed;
    logic side_a;
    logic [PALM_CNT_W-1:0] cnt;
    logic fire;
  } palm_state_t;
  localparam palm_state_t PALM_RESET = '0;

  typedef struct packed {
    seq_state_t seq;
    logic [7:0] pc;
    weld_state_t weld;
    logic valve;
    logic start;
    logic [6:0] sched;
    logic lock;
    logic err_out;
    logic prim_q;
    logic sec_q;
    force_unit_t unit_q;
    logic unit_seen;
    logic invalid;
    logic [15:0] fb;
    logic [6:0] psi;
    logic sense_en;
    logic reg_en;
  } ctrl_state_t;
  localparam ctrl_state_t CTRL_RESET = '{
    seq: sq_idle, pc: LINE_FIRST, weld: wd_idle, unit_q: unit_ma,
    valve: 1'b0, start: 1'b0, sched: 7'h00, lock: 1'b0, err_out: 1'b0,
    prim_q: 1'b0, sec_q: 1'b0, unit_seen: 1'b0, invalid: 1'b0,
    fb: 16'h0000, psi: 7'h00, sense_en: 1'b0, reg_en: 1'b0};

endpackage : weld_pkg

// >>> core/sched_select.sv
// Schedule chooser for the primary initiation.
// Assumes the external code inputs are already synchronous to sys_clk.
module sched_select (
  // Selection settings
  input wire weld_pkg::sched_src_t sched_src,
  input wire logic [6:0] use_schedule,
  // Binary code, bit 0 is sched_code_lsb_input, bit 6 sched_code_msb_input
  input wire logic [6:0] sched_code,
  // Chosen schedule
  output logic [6:0] sched
);

  // External codes saturate so a wild code never names a missing schedule
  always_comb begin
    if (sched_src == weld_pkg::src_internal) begin
      sched = use_schedule;
    end else if (sched_code > weld_pkg::SCHED_MAX) begin
      sched = weld_pkg::SCHED_MAX;
    end else begin
      sched = sched_code;
    end
  end

endmodule : sched_select

// >>> core/palm_window.sv
// Two-hand coincidence detector: one pulse when both palm inputs close
// within the window of each other.
// Assumes inputs synchronous to sys_clk and already debounced.
module palm_window #(
  parameter int WINDOW_CYC = weld_pkg::PALM_WINDOW_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Mode and inputs
  input wire logic enable,
  input wire logic palm_input_a,
  input wire logic palm_input_b,
  // One-cycle coincidence pulse
  output logic fire
);

  localparam logic [weld_pkg::PALM_CNT_W-1:0] CNT_LAST =
    weld_pkg::PALM_CNT_W'(WINDOW_CYC - 1);

  weld_pkg::palm_state_t r;
  weld_pkg::palm_state_t n;
  logic rise_a;
  logic rise_b;

  assign rise_a = palm_input_a & ~r.a_q;
  assign rise_b = palm_input_b & ~r.b_q;
  assign fire = r.fire;

  // Arm on the first closure, fire on the other one before time runs out
  always_comb begin
    n = r;
    n.fire = 1'b0;
    n.a_q = palm_input_a;
    n.b_q = palm_input_b;
    if (!enable) begin
      n.armed = 1'b0;
      n.cnt = '0;
    end else if ((rise_a && rise_b) ||
                 (r.armed && (r.side_a ? rise_b : rise_a))) begin
      n.fire = 1'b1;
      n.armed = 1'b0;
      n.cnt = '0;
    end else if (rise_a || rise_b) begin
      n.armed = 1'b1;
      n.side_a = rise_a;
      n.cnt = '0;
    end else if (r.armed) begin
      if (r.cnt == CNT_LAST) begin
        n.armed = 1'b0;
      end else begin
        n.cnt = r.cnt + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= weld_pkg::PALM_RESET;
    end else begin
      r <= n;
    end
  end

  AST_PALM_EXPIRE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    r.armed && r.cnt == CNT_LAST && !rise_a && !rise_b |=> !r.armed)
    else $error("palm window did not expire");
  AST_PALM_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !enable |=> !fire)
    else $error("palm fired while mode off");

endmodule : palm_window

// >>> testbench/machine_io_model.sv
// Machine side of the weld controller: weld timer answering the valve and
// the sequencer program store read by line address.
// Assumes prog_addr is answered in the same cycle, as the controller needs.
module machine_io_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Weld valve handshake
  input wire logic weld_valve,
  input wire logic slow,
  output logic weld_done,
  // Program store
  input wire logic [7:0] prog_addr,
  output weld_pkg::prog_line_t prog_line
);
  timeunit 1ns;
  timeprecision 100ps;

  weld_pkg::prog_line_t mem [0:255];
  logic v_q;
  int cnt;

  // Unprogrammed lines read as blank so a stray address just advances
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = '0;
    end
  end

  assign prog_line = mem[prog_addr];

  // One done pulse per valve opening; slow mode lets errors land mid-weld
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      v_q <= 1'b0;
      cnt <= 0;
      weld_done <= 1'b0;
    end else begin
      v_q <= weld_valve;
      weld_done <= (cnt == 1);
      if (weld_valve && !v_q) begin
        cnt <= slow ? 12 : 2;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : machine_io_model

// >>> testbench/tb.sv
// Self-checking bench of the weld start and error policy controller.
// Assumes the machine model file and the design package are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  weld_pkg::config_t cfg = '0;
  logic primary_initiation = 1'b0;
  logic second_initiation = 1'b0;
  logic palm_input_a = 1'b0;
  logic palm_input_b = 1'b0;
  logic [6:0] sched_code_input = 7'h00;
  logic [95:0] err_active = '0;
  logic err_routed = 1'b0;
  logic err_reset = 1'b0;
  logic force_data_ack = 1'b0;
  logic model_slow = 1'b0;
  weld_pkg::coil_t coil = '0;
  logic [7:0] press_ma_x10 = 8'h00;
  logic weld_done, weld_valve, weld_start, weld_lockout, error_output;
  logic seq_busy, seq_done, pressure_sense_en, pressure_regulate_en;
  logic force_data_invalid;
  logic [6:0] weld_sched, press_psi;
  logic [7:0] prog_addr;
  logic [15:0] current_fb;
  weld_pkg::prog_line_t prog_line;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rng_state = 32'h00008765;
  logic [6:0] codes [4] = '{7'h00, 7'h63, 7'h64, 7'h7F};
  logic [7:0] ma_pts [4] = '{8'h28, 8'hC8, 8'h1E, 8'hFA};

  // Short palm window keeps the coincidence tests quick
  weld_start_ctrl #(.PALM_WINDOW_CYC(20)) dut_u (.sys_clk(sys_clk),
    .rst_n(rst_n), .cfg(cfg), .primary_initiation(primary_initiation),
    .second_initiation(second_initiation), .palm_input_a(palm_input_a),
    .palm_input_b(palm_input_b), .sched_code_input(sched_code_input),
    .err_active(err_active), .err_routed(err_routed),
    .err_reset(err_reset), .weld_done(weld_done), .weld_valve(weld_valve),
    .weld_start(weld_start), .weld_sched(weld_sched),
    .weld_lockout(weld_lockout), .error_output(error_output),
    .prog_addr(prog_addr), .prog_line(prog_line), .seq_busy(seq_busy),
    .seq_done(seq_done), .coil(coil), .current_fb(current_fb),
    .press_ma_x10(press_ma_x10), .force_data_ack(force_data_ack),
    .press_psi(press_psi), .pressure_sense_en(pressure_sense_en),
    .pressure_regulate_en(pressure_regulate_en),
    .force_data_invalid(force_data_invalid));

  machine_io_model model_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .weld_valve(weld_valve), .slow(model_slow), .weld_done(weld_done),
    .prog_addr(prog_addr), .prog_line(prog_line));

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  function logic [31:0] rnd();
    rng_state ^= rng_state << 13;
    rng_state ^= rng_state >> 17;
    rng_state ^= rng_state << 5;
    return rng_state;
  endfunction : rnd

  // Expected PSI, transducer clamped to its 4..20 mA span
  function automatic logic [6:0] psi_of(input logic [7:0] ma);
    logic [10:0] d;
    d = (ma < 8'h28) ? 11'h000 : (ma > 8'hC8) ? 11'h0A0 : 11'(ma - 8'h28);
    return 7'((d * 11'h005) >> 3);
  endfunction : psi_of

  // Next line address of the sequencer; bit 8 set means sequence done
  function automatic logic [8:0] seq_next(input weld_pkg::prog_line_t l,
                                          input logic [7:0] pc,
                                          input logic [95:0] e);
    logic on, bit_v, hit;
    on = (l.op == weld_pkg::op_err_on_jump);
    bit_v = (l.err_sel != 7'h00 && l.err_sel <= 7'h60) ?
            e[l.err_sel - 7'h01] : 1'b0;
    if (l.err_sel == 7'h00) hit = on ? (|e) : ~(|e);
    else hit = (l.err_sel <= 7'h60) && (on ? bit_v : ~bit_v);
    if (!on && l.op != weld_pkg::op_err_off_jump) hit = 1'b0;
    if (l.op == weld_pkg::op_end) return 9'h100;
    if (hit) return {1'b0, l.target};
    if (pc == 8'hC8) return 9'h100;
    return {1'b0, pc + 8'h01};
  endfunction : seq_next

  task automatic step();
    @(posedge sys_clk);
    #2;
  endtask : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // Request a weld (0 primary, 1 second, 2 palm pair gap cycles apart)
  task automatic init(input int kind, input int gap, input logic ok,
                      input logic [6:0] es);
    logic seen;
    logic [6:0] s;
    seen = 1'b0;
    s = 7'h00;
    if (kind == 0) primary_initiation = 1'b1;
    else if (kind == 1) second_initiation = 1'b1;
    else begin
      palm_input_a = 1'b1;
      repeat (gap) step();
      palm_input_b = 1'b1;
    end
    repeat (5) begin
      step();
      if (weld_start === 1'b1) begin
        seen = 1'b1;
        s = weld_sched;
      end
    end
    {primary_initiation, second_initiation} = 2'h0;
    {palm_input_a, palm_input_b} = 2'h0;
    // One low edge so that a following call makes a fresh rising request
    step();
    chk(seen, ok);
    if (ok) chk(s, es);
    for (int i = 0; i < 40 && weld_valve !== 1'b0; i++) step();
    chk(weld_valve, 1'b0);
  endtask : init

  // Run one program and follow it line by line against the reference
  task automatic seq_run(input logic [95:0] e);
    logic [8:0] exp;
    err_active = e;
    cfg.seq_enable = 1'b1;
    step();
    exp = 9'h001;
    for (int i = 0; i < 60 && !exp[8]; i++) begin
      chk({seq_busy, prog_addr}, {1'b1, exp[7:0]});
      exp = seq_next(model_u.mem[exp[7:0]], exp[7:0], e);
      step();
    end
    chk({seq_done, seq_busy}, {exp[8], ~exp[8]});
    cfg.seq_enable = 1'b0;
    step();
    chk({seq_busy, seq_done, prog_addr}, 10'h001);
  endtask : seq_run

  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    logic [6:0] c;
    logic [7:0] x;
    logic [31:0] r;
    int k;
    repeat (8) @(posedge sys_clk);
    chk({weld_valve, weld_start, weld_lockout, error_output}, 4'h0);
    chk({seq_busy, seq_done, prog_addr}, 10'h001);
    #2 rst_n = 1'b1;
    step();
    cfg.force_unit = weld_pkg::unit_psi;
    step();
    step();
    chk(force_data_invalid, 1'b1);
    force_data_ack = 1'b1;
    step();
    force_data_ack = 1'b0;
    step();
    chk(force_data_invalid, 1'b0);
    for (int p = 0; p < 4; p++) begin
      cfg.press_mode = weld_pkg::press_mode_t'(p);
      for (int i = 0; i < 5; i++) begin
        x = (i < 4) ? ma_pts[i] : 8'(rnd());
        press_ma_x10 = x;
        step();
        step();
        chk({pressure_sense_en, pressure_regulate_en}, {p[0], p[1]});
        chk(press_psi, (p == 0) ? 7'h00 : psi_of(x));
      end
    end
    // Leaving PSI units zeroes the reading and flags stored data again
    cfg.force_unit = weld_pkg::unit_lb;
    step();
    step();
    chk({force_data_invalid, press_psi}, 8'h80);
    coil = {16'(rnd()), 16'(rnd()), 16'(rnd())};
    for (int p = 0; p < 3; p++) begin
      cfg.fb_src = weld_pkg::fb_src_t'(p);
      step();
      step();
      chk(current_fb, (p == 0) ? coil.primary : (p == 1) ?
          coil.secondary : coil.sec_with_pri);
    end
    cfg.use_schedule = 7'h01 + 7'(rnd() % 99);
    init(0, 0, 1'b1, cfg.use_schedule);
    cfg.sched_src = weld_pkg::src_external;
    for (int i = 0; i < 6; i++) begin
      c = (i < 4) ? codes[i] : 7'(rnd());
      sched_code_input = c;
      init(0, 0, 1'b1, (c > 7'h63) ? 7'h63 : c);
    end
    sched_code_input = 7'h2A;
    cfg.dual_hand_initiation = 1'b1;
    init(2, 0, 1'b1, 7'h2A);
    init(2, 5, 1'b1, 7'h2A);
    init(2, 40, 1'b0, 7'h2A);
    init(1, 0, 1'b1, 7'h14);
    init(0, 0, 1'b1, 7'h2A);
    // Error arrives mid-weld under each response policy
    model_slow = 1'b1;
    for (int p = 0; p < 3; p++) begin
      cfg.policy = weld_pkg::policy_t'(p);
      primary_initiation = 1'b1;
      step();
      step();
      primary_initiation = 1'b0;
      err_routed = 1'b1;
      step();
      err_routed = 1'b0;
      chk(error_output, 1'b1);
      chk(weld_lockout, p != 1);
      repeat (20) step();
      chk({weld_valve, error_output}, {p == 2, 1'b0});
      if (p != 2) init(0, 0, p == 1, 7'h2A);
      err_reset = 1'b1;
      step();
      err_reset = 1'b0;
      step();
      chk({weld_lockout, weld_valve}, 2'h0);
      init(0, 0, 1'b1, 7'h2A);
    end
    for (int run = 0; run < 3; run++) begin
      k = rnd() % 96;
      for (int i = 1; i <= 200; i++) begin
        r = rnd();
        model_u.mem[i] = '{op: weld_pkg::opcode_t'(r[2:0] % 3'h5),
          err_sel: (r[9:8] == 2'h0) ? 7'h00 : (r[9:8] == 2'h1) ?
                   7'(k + 1) : r[16:10],
          target: 8'h01 + 8'(r[31:24] % 200)};
      end
      seq_run((run == 0) ? (96'h1 << k) : (run == 1) ? '0 :
              {rnd(), rnd(), rnd()});
    end
    print_verdict();
  end
endmodule : tb
